/* File: common/spd_cfg.svh */
// register page decoder constants
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
`define SPD_PAGE_ADDR      8'ha7
`define SPD_PAGE_RESET     8'h00
`define SPD_PAGE_DEFAULT   8'h00
`define SPD_PAGE_ALT       8'h0f
`define SPD_SPACE_LO       8'h80
`define SPD_ADDR_CURREF    8'hb9
`define SPD_ADDR_TOUCH     8'hde
`define SPD_ADDR_SERIAL    8'h99
`define SPD_ZERO_DATA      8'h00
`endif

/* File: common/spd_pkg.sv */
// register page decoder types
package spd_pkg;
    // one register bus access from the core
    typedef struct packed
    {
        logic       direct;  // direct addressing mode
        logic       wr;      // write strobe
        logic       rd;      // read strobe
        logic [7:0] addr;    // register address
        logic [7:0] wdata;   // write data
    } spd_access_type;

    // which register answers the access
    typedef enum
    {
        SPD_SEL_NONE,
        SPD_SEL_PAGE,
        SPD_SEL_CURREF,
        SPD_SEL_SCAN_END,
        SPD_SEL_TOUCH_PM,
        SPD_SEL_SERIAL,
        SPD_SEL_P0_DRIVE
    } spd_sel_type;
endpackage

/* File: hdl/spd_decoder.sv */
// register page select and paged address decode
// How it works
// - eight-bit page register selects target page
// - page register answers at 0xa7 always
// - reset returns page to zero
// - decode only direct accesses 0x80..0xff
// - shared registers answer on every page
// - 0xde: scan end page0, power page f
// - 0x99: serial page0, drive page f
// - unassigned locations are reserved
`timescale 1ns/1ps
`include "spd_cfg.svh"
module spd_decoder
(
    // clock and reset
    input  wire logic                  CLOCK_IN,
    input  wire logic                  ARST_N_IN,
    // register bus from the core
    input  wire spd_pkg::spd_access_type BUS_IN,
    // register bus answer
    output logic [7:0]                 RDATA_OUT,
    output logic                       RVALID_OUT,
    // current page for the peripherals
    output logic [7:0]                 PAGE_OUT,
    // write strobes to the paged peripheral registers
    output logic                       WR_CURREF_OUT,
    output logic                       WR_SCAN_END_OUT,
    output logic                       WR_TOUCH_PM_OUT,
    output logic                       WR_SERIAL_OUT,
    output logic                       WR_P0_DRIVE_OUT,
    output logic [7:0]                 WDATA_OUT,
    // read data back from those peripheral registers
    input  wire logic [7:0]            CURREF_IN,
    input  wire logic [7:0]            SCAN_END_IN,
    input  wire logic [7:0]            TOUCH_PM_IN,
    input  wire logic [7:0]            SERIAL_IN,
    input  wire logic [7:0]            P0_DRIVE_IN
);

    // overview of the access path:
    // - one access per clock, presented as a level on the bus struct
    // - the decode looks at the page in force before the access, so a
    //   write to the page register only retargets the next access
    // - every answer is registered, so read data, valid and strobes
    //   all show at the taking edge, one clock after the access is presented
    // - reads of unmapped or non-direct locations still pulse valid,
    //   so the core never waits on a location that nobody owns
    // - only a handful of paged targets are decoded here; everything
    //   else on either page reads zero and swallows writes
    // - the page is compared whole: pages other than zero and f reach
    //   only the page register itself and the shared registers
    // limitation: peripheral read data is taken combinationally in the
    // access cycle, so it must be settled by the taking edge

    spd_pkg::spd_sel_type sel;         // decoded target
    logic [7:0]   page_q, page_d;      // page select register
    logic [7:0]   rdata_q, rdata_d;    // registered read answer
    logic         rvalid_q, rvalid_d;  // answer valid pulse
    logic [4:0]   wr_q, wr_d;          // peripheral write strobes
    logic [7:0]   wdata_q, wdata_d;    // forwarded write data
    // strobe bit map: 0 curref, 1 scan end, 2 touch pm,
    // 3 serial, 4 port 0 drive

    // address decode; the page value is compared whole, so pages
    // other than zero and f reach only the shared registers
    always_comb
    begin
        // default: nothing answers
        sel = spd_pkg::SPD_SEL_NONE;
        // indirect accesses and the low half never reach the paged space
        if (!BUS_IN.direct || BUS_IN.addr < `SPD_SPACE_LO)
        begin
            sel = spd_pkg::SPD_SEL_NONE;
        end
        // page register sits on every page so software can always leave
        else if (BUS_IN.addr == `SPD_PAGE_ADDR)
        begin
            sel = spd_pkg::SPD_SEL_PAGE;
        end
        // shared register: page value ignored
        else if (BUS_IN.addr == `SPD_ADDR_CURREF)
        begin
            sel = spd_pkg::SPD_SEL_CURREF;
        end
        // same address, two owners: scan end on the default page
        else if (BUS_IN.addr == `SPD_ADDR_TOUCH &&
                 page_q == `SPD_PAGE_DEFAULT)
        begin
            sel = spd_pkg::SPD_SEL_SCAN_END;
        end
        // and touch power management on the alternate page
        else if (BUS_IN.addr == `SPD_ADDR_TOUCH &&
                 page_q == `SPD_PAGE_ALT)
        begin
            sel = spd_pkg::SPD_SEL_TOUCH_PM;
        end
        // serial data buffer only on the default page
        else if (BUS_IN.addr == `SPD_ADDR_SERIAL &&
                 page_q == `SPD_PAGE_DEFAULT)
        begin
            sel = spd_pkg::SPD_SEL_SERIAL;
        end
        // port 0 drive strength only on the alternate page
        else if (BUS_IN.addr == `SPD_ADDR_SERIAL &&
                 page_q == `SPD_PAGE_ALT)
        begin
            sel = spd_pkg::SPD_SEL_P0_DRIVE;
        end
        // anything else on this page is reserved
        else
        begin
            sel = spd_pkg::SPD_SEL_NONE;
        end
    end

    // next values for page, answer and strobes
    // defaults: page holds, answer zero, no strobe; the write data is
    // forwarded every cycle since a peripheral only looks at it when
    // its own strobe is high, which saves a mux on the data path
    always_comb
    begin
        // hold page unless written
        page_d   = page_q;
        rdata_d  = `SPD_ZERO_DATA;
        // every read is answered, mapped or not
        rvalid_d = BUS_IN.rd;
        wr_d     = 5'h00;
        wdata_d  = BUS_IN.wdata;
        // a write to the page register retargets later accesses
        if (BUS_IN.wr && sel == spd_pkg::SPD_SEL_PAGE)
        begin
            page_d = BUS_IN.wdata;
        end
        // strobes only for mapped targets, so reserved writes vanish
        if (BUS_IN.wr)
        begin
            case (sel)
                spd_pkg::SPD_SEL_CURREF:   wr_d = 5'h01;
                spd_pkg::SPD_SEL_SCAN_END: wr_d = 5'h02;
                spd_pkg::SPD_SEL_TOUCH_PM: wr_d = 5'h04;
                spd_pkg::SPD_SEL_SERIAL:   wr_d = 5'h08;
                spd_pkg::SPD_SEL_P0_DRIVE: wr_d = 5'h10;
                default:                   wr_d = 5'h00;
            endcase
        end
        // read mux; reads see the page in force before this access
        if (BUS_IN.rd)
        begin
            case (sel)
                spd_pkg::SPD_SEL_PAGE:     rdata_d = page_q;
                spd_pkg::SPD_SEL_CURREF:   rdata_d = CURREF_IN;
                spd_pkg::SPD_SEL_SCAN_END: rdata_d = SCAN_END_IN;
                spd_pkg::SPD_SEL_TOUCH_PM: rdata_d = TOUCH_PM_IN;
                spd_pkg::SPD_SEL_SERIAL:   rdata_d = SERIAL_IN;
                spd_pkg::SPD_SEL_P0_DRIVE: rdata_d = P0_DRIVE_IN;
                default:                   rdata_d = `SPD_ZERO_DATA;
            endcase
        end
    end

    // registers
    // asynchronous clear puts the block on the default page at once,
    // so the very first access after release targets page zero
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        // reset: default page, quiet bus answer
        if (!ARST_N_IN)
        begin
            page_q   <= `SPD_PAGE_RESET;
            rdata_q  <= `SPD_ZERO_DATA;
            rvalid_q <= 1'b0;
            wr_q     <= 5'h00;
            wdata_q  <= `SPD_ZERO_DATA;
        end
        // normal running: take the next values
        else
        begin
            page_q   <= page_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            wr_q     <= wr_d;
            wdata_q  <= wdata_d;
        end
    end

    // outputs straight from flip-flops
    // no logic after the registers, so the core and the peripherals
    // see clean timing from the clock edge
    // read answer and its valid pulse
    assign RDATA_OUT       = rdata_q;
    assign RVALID_OUT      = rvalid_q;
    // current page for anyone who needs to know it
    assign PAGE_OUT        = page_q;
    // one-hot write strobes, bit order as in the next-value case
    assign WR_CURREF_OUT   = wr_q[0];
    assign WR_SCAN_END_OUT = wr_q[1];
    assign WR_TOUCH_PM_OUT = wr_q[2];
    assign WR_SERIAL_OUT   = wr_q[3];
    assign WR_P0_DRIVE_OUT = wr_q[4];
    // write data, aligned with the strobes
    assign WDATA_OUT       = wdata_q;

endmodule // spd_decoder

/* File: tb/spd_monitor.sv */
// checker watching the page decoder ports
`timescale 1ns/1ps
module spd_monitor
(
    // clock, reset and bus
    input wire logic                    CLOCK_IN,
    input wire logic                    ARST_N_IN,
    input wire spd_pkg::spd_access_type BUS_IN,
    // answers and peripheral data
    input wire logic [7:0]              RDATA_OUT,
    input wire logic                    RVALID_OUT,
    input wire logic [7:0]              PAGE_OUT,
    input wire logic                    WR_SERIAL_OUT,
    input wire logic                    WR_P0_DRIVE_OUT,
    input wire logic [7:0]              CURREF_IN,
    input wire logic [7:0]              SCAN_END_IN
);
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (!ARST_N_IN);
    // direct strobes and page address hit
    wire dr = BUS_IN.direct & BUS_IN.rd;
    wire dw = BUS_IN.direct & BUS_IN.wr;
    wire pg = BUS_IN.addr == 8'ha7;
    wire [7:0] ad = BUS_IN.addr;
    property p_rv; BUS_IN.rd |=> RVALID_OUT; endproperty
    a_rv: assert property (p_rv) else $error("no answer");
    property p_pw; dw && pg |=> PAGE_OUT == $past(BUS_IN.wdata); endproperty
    a_pw: assert property (p_pw) else $error("page write");
    property p_ph; !(dw && pg) |=> $stable(PAGE_OUT); endproperty
    a_ph: assert property (p_ph) else $error("page moved");
    property p_pr; dr && pg |=> RDATA_OUT == $past(PAGE_OUT); endproperty
    a_pr: assert property (p_pr) else $error("page read");
    property p_cr; dr && ad == 8'hb9 |=> RDATA_OUT == $past(CURREF_IN);
    endproperty
    a_cr: assert property (p_cr) else $error("shared read");
    property p_se; dr && ad == 8'hde && PAGE_OUT == 8'h00
        |=> RDATA_OUT == $past(SCAN_END_IN); endproperty
    a_se: assert property (p_se) else $error("scan end read");
    property p_sd; dw && ad == 8'h99 && PAGE_OUT == 8'h0f
        |=> WR_P0_DRIVE_OUT && !WR_SERIAL_OUT; endproperty
    a_sd: assert property (p_sd) else $error("drive strobe");
    property p_nd; BUS_IN.rd && !BUS_IN.direct |=> RDATA_OUT == 8'h00;
    endproperty
    a_nd: assert property (p_nd) else $error("indirect read");
endmodule // spd_monitor
bind spd_decoder spd_monitor u_mon (.*);

/* File: tb/spd_periph.sv */
// peripheral register stand-ins behind the decoder
`timescale 1ns/1ps
module spd_periph
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // strobes: curref, scan end, touch pm, serial, p0 drive
    input  wire logic [4:0] wr_in,
    input  wire logic [7:0] wd_in,
    output logic [7:0]      q_out [5]
);
    // distinct reset values so a wrong mux leg shows up
    always_ff @(posedge clk_in or negedge rst_n_in)
        for (int i = 0; i < 5; i++)
            if (!rst_n_in)
                q_out[i] <= {4'h1, 4'(i)};
            else if (wr_in[i])
                q_out[i] <= wd_in;
endmodule // spd_periph

/* File: tb/tb.sv */
// testbench for the register page decoder
`timescale 1ns/1ps
module tb;
    logic                    CLOCK_IN = 1'b0;
    logic                    ARST_N_IN = 1'b0;
    spd_pkg::spd_access_type bus = '0;
    logic [7:0]              rd, pg, wd, q [5];
    logic [4:0]              wr;
    logic                    rv;
    int                      failures = 0;
    int                      n_tests = 0;
    initial forever #20 CLOCK_IN = ~CLOCK_IN;
    spd_decoder DUT (.CLOCK_IN, .ARST_N_IN, .BUS_IN(bus), .RDATA_OUT(rd),
        .RVALID_OUT(rv), .PAGE_OUT(pg), .WR_CURREF_OUT(wr[0]),
        .WR_SCAN_END_OUT(wr[1]), .WR_TOUCH_PM_OUT(wr[2]),
        .WR_SERIAL_OUT(wr[3]), .WR_P0_DRIVE_OUT(wr[4]), .WDATA_OUT(wd),
        .CURREF_IN(q[0]), .SCAN_END_IN(q[1]), .TOUCH_PM_IN(q[2]),
        .SERIAL_IN(q[3]), .P0_DRIVE_IN(q[4]));
    spd_periph u_per (.clk_in(CLOCK_IN), .rst_n_in(ARST_N_IN), .wr_in(wr),
        .wd_in(wd), .q_out(q));
    // compare and count
    task automatic chk(input string nm, input logic [7:0] ex, got);
        n_tests++;
        if (got !== ex)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // m = {direct, wr, rd}; one access, judged just after the taking edge, then an idle cycle
    task automatic acc(input logic [2:0] m, input logic [7:0] a, d, ex);
        @(posedge CLOCK_IN);
        bus <= '{m[2], m[1], m[0], a, d};
        @(posedge CLOCK_IN);
        bus <= '0;
        #1;
        if (m[0])
            chk($sformatf("read %h", a), ex, rd);
    endtask
    // odd page: only global registers answer
    task automatic t_odd;
        chk("reset page", 8'h00, pg);
        acc(3'h6, 8'ha7, 8'h5a, 8'h00);
        chk("page", 8'h5a, pg);
        acc(3'h5, 8'ha7, 8'h00, 8'h5a);
        acc(3'h5, 8'hde, 8'h00, 8'h00);
        acc(3'h6, 8'hb9, 8'h77, 8'h00);
        acc(3'h5, 8'hb9, 8'h00, 8'h77);
        $display("t_odd done");
    endtask
    // default page decode, reserved and indirect
    task automatic t_p0;
        acc(3'h6, 8'ha7, 8'h00, 8'h00);
        acc(3'h6, 8'h99, 8'h33, 8'h00);
        acc(3'h5, 8'h99, 8'h00, 8'h33);
        acc(3'h5, 8'hde, 8'h00, 8'h11);
        acc(3'h6, 8'hde, 8'h21, 8'h00);
        acc(3'h5, 8'hde, 8'h00, 8'h21);
        acc(3'h6, 8'h80, 8'h55, 8'h00);
        acc(3'h5, 8'h80, 8'h00, 8'h00);
        acc(3'h1, 8'hb9, 8'h00, 8'h00);
        acc(3'h5, 8'hb9, 8'h00, 8'h77);
        $display("t_p0 done");
    endtask
    // alternate page reaches the other registers
    task automatic t_pf;
        acc(3'h6, 8'ha7, 8'h0f, 8'h00);
        acc(3'h5, 8'h99, 8'h00, 8'h14);
        acc(3'h6, 8'h99, 8'h44, 8'h00);
        acc(3'h5, 8'h99, 8'h00, 8'h44);
        acc(3'h5, 8'hde, 8'h00, 8'h12);
        acc(3'h6, 8'hde, 8'h66, 8'h00);
        acc(3'h5, 8'hde, 8'h00, 8'h66);
        $display("t_pf done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        repeat (16) @(posedge CLOCK_IN);
        ARST_N_IN <= 1'b1;
        t_odd();
        t_p0();
        t_pf();
        tally_and_finish();
    end
endmodule // tb
